// ---- verilog/ctl_bank.sv ----
// channel two level configuration register bank
// Contract
// - The gain register holds a six-bit analog gain code in bits 7..2, code n giving n dB up to 42.
// - The gain register resets to zero, giving 0 dB analog gain.
// - Gain bit 1 is writable reserved, bit 0 read-only reserved, both reset to zero.
// - The eight-bit volume code mutes the output at code zero.
// - Nonzero volume codes step 0.5 dB from -100 dB at code 1 to +27 dB at code 255.
// - The volume register resets to 0xc9, unity gain.
// - The trim register holds a four-bit gain trim code in bits 7..4, -0.8 dB to +0.7 dB.
// - The trim register resets to 0x80, no offset.
// - Trim bits 3..0 are reserved, read-only and read zero.
// - The phase register holds an eight-bit delay of n modulator clocks.
`timescale 1ns/100ps
`default_nettype none
`include "ctl_map.svh"
module ctl_bank (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire ctl_pkg::ctl_req_s req_in,
    input  wire logic              sample_tick_in,
    output logic [7:0]             rdata_out,
    output logic                   rvalid_out,
    output logic                   hit_out,
    output ctl_pkg::ctl_cfg_s      active_out
);
    import ctl_pkg::*;

    logic [7:0] gain_q;
    logic [7:0] vol_q;
    logic [7:0] trim_q;
    logic [7:0] phase_q;
    ctl_cfg_s   shadow;

    function automatic logic is_ours(input logic [7:0] a);
        is_ours = (a == `CTL_ADDR_GAIN) || (a == `CTL_ADDR_VOL) ||
                  (a == `CTL_ADDR_TRIM) || (a == `CTL_ADDR_PHASE);
    endfunction : is_ours

    // =====================================================
    // register writes
    // read-only reserved bits masked so they cannot be set by mistake
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gain_q  <= `CTL_RST_GAIN;
            vol_q   <= `CTL_RST_VOL;
            trim_q  <= `CTL_RST_TRIM;
            phase_q <= `CTL_RST_PHASE;
        end else if (req_in.wr) begin
            if (req_in.addr == `CTL_ADDR_GAIN) begin
                gain_q <= req_in.wdata & `CTL_GAIN_WMASK;
            end
            if (req_in.addr == `CTL_ADDR_VOL) begin
                vol_q <= req_in.wdata;
            end
            if (req_in.addr == `CTL_ADDR_TRIM) begin
                trim_q <= req_in.wdata & `CTL_TRIM_WMASK;
            end
            if (req_in.addr == `CTL_ADDR_PHASE) begin
                phase_q <= req_in.wdata;
            end
        end
    end

    // =====================================================
    // read path
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
            hit_out    <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            hit_out    <= req_in.rd && is_ours(req_in.addr);
            unique case (req_in.addr)
                `CTL_ADDR_GAIN:  rdata_out <= gain_q;
                `CTL_ADDR_VOL:   rdata_out <= vol_q;
                `CTL_ADDR_TRIM:  rdata_out <= trim_q;
                `CTL_ADDR_PHASE: rdata_out <= phase_q;
                default:         rdata_out <= 8'h00;
            endcase
        end
    end

    // =====================================================
    // decoded settings; reserved gain codes pass through unchanged
    always_comb begin
        shadow.gain  = gain_q[7:2];
        shadow.vol   = vol_q;
        shadow.mute  = (vol_q == `CTL_VOL_MUTE);
        shadow.trim  = trim_q[7:4];
        shadow.phase = phase_q;
    end

    ctl_cfg_apply u_apply (
        .clk_sys_in     (clk_sys_in),
        .rst_n_in       (rst_n_in),
        .sample_tick_in (sample_tick_in),
        .shadow_in      (shadow),
        .active_out     (active_out)
    );

    // =====================================================
    // checks
    a_gain_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        gain_q[1:0] == 2'b00 || gain_q[0] == 1'b0)
        else $error("gain bit 0 set");
    a_trim_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        trim_q[3:0] == 4'h0)
        else $error("trim low bits set");
    a_gain_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == `CTL_ADDR_GAIN |=> gain_q[7:1] == $past(req_in.wdata[7:1]))
        else $error("gain write lost");
    a_vol_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == `CTL_ADDR_VOL |=> vol_q == $past(req_in.wdata))
        else $error("volume write lost");
    a_trim_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == `CTL_ADDR_TRIM |=> trim_q[7:4] == $past(req_in.wdata[7:4]))
        else $error("trim write lost");
    a_phase_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.wr && req_in.addr == `CTL_ADDR_PHASE |=> phase_q == $past(req_in.wdata))
        else $error("phase write lost");
    a_mute_code: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        active_out.mute == (active_out.vol == `CTL_VOL_MUTE))
        else $error("mute mismatch");
    a_apply_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !sample_tick_in |=> $stable(active_out))
        else $error("settings moved off boundary");
    a_apply_take: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        sample_tick_in |=> active_out.vol == $past(vol_q) && active_out.gain == $past(gain_q[7:2]))
        else $error("settings not taken");
    a_read_data: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd && req_in.addr == `CTL_ADDR_VOL && !req_in.wr |=> rdata_out == vol_q)
        else $error("volume readback wrong");

    // =====================================================
    // check helpers
    // marks the first edge after reset, where reset values must still show
    logic init_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_q <= 1'b0;
        end else begin
            init_q <= 1'b1;
        end
    end

    // =====================================================
    // request sequences
    sequence s_gain_wr;
        req_in.wr && req_in.addr == `CTL_ADDR_GAIN;
    endsequence

    sequence s_vol_wr;
        req_in.wr && req_in.addr == `CTL_ADDR_VOL;
    endsequence

    sequence s_trim_wr;
        req_in.wr && req_in.addr == `CTL_ADDR_TRIM;
    endsequence

    sequence s_phase_wr;
        req_in.wr && req_in.addr == `CTL_ADDR_PHASE;
    endsequence

    sequence s_tick;
        sample_tick_in;
    endsequence

    sequence s_rd_ours;
        req_in.rd && is_ours(req_in.addr);
    endsequence

    sequence s_rd_stray;
        req_in.rd && !is_ours(req_in.addr);
    endsequence

    // =====================================================
    // read handshake checks
    a_rvalid_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd |=> rvalid_out)
        else $error("read valid missing");

    a_rvalid_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !req_in.rd |=> !rvalid_out)
        else $error("read valid without request");

    a_hit_mapped: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_rd_ours |=> hit_out && rvalid_out)
        else $error("mapped read not flagged");

    a_hit_stray: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_rd_stray |=> !hit_out && rdata_out == 8'h00)
        else $error("unmapped read not empty");

    a_hit_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !req_in.rd |=> !hit_out)
        else $error("hit without request");

    // =====================================================
    // readback checks
    a_read_gain: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd && !req_in.wr && req_in.addr == `CTL_ADDR_GAIN |=> rdata_out == gain_q)
        else $error("gain readback wrong");

    a_read_trim: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd && !req_in.wr && req_in.addr == `CTL_ADDR_TRIM |=> rdata_out == trim_q)
        else $error("trim readback wrong");

    a_read_phase: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd && !req_in.wr && req_in.addr == `CTL_ADDR_PHASE |=> rdata_out == phase_q)
        else $error("phase readback wrong");

    // a read beside a write to the same register returns the old value
    a_read_old_vol: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.rd && s_vol_wr |=> rdata_out == $past(vol_q))
        else $error("volume read not old value");

    // =====================================================
    // register hold checks
    a_stray_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.wr && !is_ours(req_in.addr) |=>
        {gain_q, vol_q, trim_q, phase_q} == $past({gain_q, vol_q, trim_q, phase_q}))
        else $error("unmapped write changed a register");

    a_gain_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(req_in.wr && req_in.addr == `CTL_ADDR_GAIN) |=> $stable(gain_q))
        else $error("gain changed without write");

    a_vol_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(req_in.wr && req_in.addr == `CTL_ADDR_VOL) |=> $stable(vol_q))
        else $error("volume changed without write");

    a_trim_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(req_in.wr && req_in.addr == `CTL_ADDR_TRIM) |=> $stable(trim_q))
        else $error("trim changed without write");

    a_phase_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(req_in.wr && req_in.addr == `CTL_ADDR_PHASE) |=> $stable(phase_q))
        else $error("phase changed without write");

    a_gain_spare_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_gain_wr |=> gain_q[1] == $past(req_in.wdata[1]) && !gain_q[0])
        else $error("gain spare bits wrong");

    a_trim_spare_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_trim_wr |=> trim_q[3:0] == 4'h0)
        else $error("trim spare bits stored");

    // =====================================================
    // reset value checks
    a_reset_gain: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> gain_q == `CTL_RST_GAIN)
        else $error("gain reset value wrong");

    a_reset_vol: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> vol_q == `CTL_RST_VOL)
        else $error("volume reset value wrong");

    a_reset_trim: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> trim_q == `CTL_RST_TRIM)
        else $error("trim reset value wrong");

    a_reset_phase: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> phase_q == `CTL_RST_PHASE)
        else $error("phase reset value wrong");

    a_reset_active: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> active_out.vol == `CTL_RST_VOL && !active_out.mute &&
        active_out.gain == 6'(`CTL_RST_GAIN >> 2) && active_out.trim == 4'(`CTL_RST_TRIM >> 4))
        else $error("active reset value wrong");

    a_reset_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !init_q |-> !rvalid_out && !hit_out && rdata_out == 8'h00)
        else $error("read outputs not idle after reset");

    // =====================================================
    // write to signal path checks
    a_vol_to_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_vol_wr ##1 s_tick |=> active_out.vol == $past(req_in.wdata, 2))
        else $error("volume not applied at boundary");

    a_mute_to_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_vol_wr ##1 s_tick |=> active_out.mute == ($past(req_in.wdata, 2) == `CTL_VOL_MUTE))
        else $error("mute not applied at boundary");

    a_gain_to_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_gain_wr ##1 s_tick |=> active_out.gain == $past(req_in.wdata[7:2], 2))
        else $error("gain not applied at boundary");

    a_trim_to_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_trim_wr ##1 s_tick |=> active_out.trim == $past(req_in.wdata[7:4], 2))
        else $error("trim not applied at boundary");

    a_phase_to_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_phase_wr ##1 s_tick |=> active_out.phase == $past(req_in.wdata, 2))
        else $error("phase not applied at boundary");

    // a stored code must wait for the boundary before it reaches the path
    a_vol_waits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_vol_wr ##1 !sample_tick_in |=> active_out.vol == $past(active_out.vol))
        else $error("volume applied early");

    a_apply_mute: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_tick |=> active_out.mute == ($past(vol_q) == `CTL_VOL_MUTE))
        else $error("mute not taken at boundary");

    a_apply_rest: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_tick |=> active_out.trim == $past(trim_q[7:4]) && active_out.phase == $past(phase_q))
        else $error("trim or phase not taken");
endmodule : ctl_bank
`default_nettype wire

// ---- verilog/ctl_map.svh ----
// register map and field constants for the channel two level configuration bank
`ifndef CTL_MAP_SVH
`define CTL_MAP_SVH
`define CTL_ADDR_GAIN       8'h42
`define CTL_ADDR_VOL        8'h43
`define CTL_ADDR_TRIM       8'h44
`define CTL_ADDR_PHASE      8'h45
`define CTL_RST_GAIN        8'h00
`define CTL_RST_VOL         8'hc9
`define CTL_RST_TRIM        8'h80
`define CTL_RST_PHASE       8'h00
`define CTL_GAIN_MAX        6'h2a
`define CTL_VOL_MUTE        8'h00
`define CTL_GAIN_WMASK      8'hfe
`define CTL_TRIM_WMASK      8'hf0
`endif

// ---- verilog/ctl_pkg.sv ----
// types for the channel two level configuration bank
`default_nettype none
package ctl_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctl_req_s;

    typedef struct packed {
        logic [5:0] gain;
        logic [7:0] vol;
        logic       mute;
        logic [3:0] trim;
        logic [7:0] phase;
    } ctl_cfg_s;
endpackage : ctl_pkg
`default_nettype wire

// ---- verilog/ctl_cfg_apply.sv ----
// sample-boundary transfer of the channel settings into the signal path
`timescale 1ns/100ps
`default_nettype none
`include "ctl_map.svh"
module ctl_cfg_apply (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              sample_tick_in,
    input  wire ctl_pkg::ctl_cfg_s shadow_in,
    output var  ctl_pkg::ctl_cfg_s active_out
);
    import ctl_pkg::*;

    // =====================================================
    // active copy
    // whole set moves at once so no sample sees a mix
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_out.gain  <= 6'(`CTL_RST_GAIN >> 2);
            active_out.vol   <= `CTL_RST_VOL;
            active_out.mute  <= 1'b0;
            active_out.trim  <= 4'(`CTL_RST_TRIM >> 4);
            active_out.phase <= `CTL_RST_PHASE;
        end else if (sample_tick_in) begin
            active_out <= shadow_in;
        end
    end
endmodule : ctl_cfg_apply
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the channel two level configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ctl_pkg::*;
    // ==========================================
    // clock, reset, stimulus nets
    logic       clk_sys_in = 1'b0;
    logic       rst_n_in   = 1'b0;
    ctl_req_s   req        = '0;
    logic       tick       = 1'b0;
    logic [7:0] rdata;
    logic       rvalid;
    logic       hit;
    ctl_cfg_s   act;
    ctl_cfg_s   last;
    logic [7:0] v [4];
    int         err_total  = 0;
    int         cmp_count  = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    ctl_bank uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
        .sample_tick_in(tick), .rdata_out(rdata), .rvalid_out(rvalid), .hit_out(hit),
        .active_out(act));
    // ==========================================
    // helpers
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic ctl_cfg_s mk();
        mk.gain  = v[0][7:2];
        mk.vol   = v[1];
        mk.mute  = (v[1] == 8'h00);
        mk.trim  = v[2][7:4];
        mk.phase = v[3];
    endfunction : mk
    // the bus and tick tasks start 1 ns after a rising edge and end the same way
    task bus_wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1; req.addr = a; req.wdata = d;
        @(posedge clk_sys_in); #1 req.wr = 1'b0;
    endtask : bus_wr
    task bus_rd(input logic [7:0] a, input logic [7:0] e, input logic eh);
        req.rd = 1'b1; req.addr = a;
        @(posedge clk_sys_in); #1 req.rd = 1'b0;
        chk("rvalid", 32'(rvalid), 32'(1'b1));
        chk("rdata", 32'(rdata), 32'(e));
        chk("hit", 32'(hit), 32'(eh));
    endtask : bus_rd
    task read_all();
        for (int i = 0; i < 4; i++) bus_rd(8'(8'h42 + i), v[i], 1'b1);
    endtask : read_all
    // new codes must not leak out before the tick, then all land together
    task tick_chk();
        chk("active hold", 32'(act), 32'(last));
        tick = 1'b1;
        @(posedge clk_sys_in); #1 tick = 1'b0;
        last = mk();
        chk("active", 32'(act), 32'(last));
    endtask : tick_chk
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // ==========================================
    // watchdog
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'ha552));
        v = '{8'h00, 8'hc9, 8'h80, 8'h00};
        repeat (10) @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        last = mk();
        chk("active reset", 32'(act), 32'(last));
        read_all();
        bus_rd(8'h41, 8'h00, 1'b0);
        bus_rd(8'h46, 8'h00, 1'b0);
        $display("test reset done");
        bus_wr(8'h42, 8'hab);
        bus_wr(8'h43, 8'h00);
        bus_wr(8'h44, 8'hff);
        bus_wr(8'h45, 8'hff);
        bus_wr(8'h46, 8'h55);
        v = '{8'haa, 8'h00, 8'hf0, 8'hff};
        read_all();
        tick_chk();
        $display("test corners done");
        for (int n = 0; n < 40; n++) begin
            v[0] = {6'($urandom_range(42)), 1'($urandom), 1'b0};
            v[1] = 8'($urandom);
            v[2] = {4'($urandom), 4'h0};
            v[3] = 8'($urandom);
            if (n == 3) v[1] = 8'h01;
            if (n == 4) v[1] = 8'hff;
            for (int i = 0; i < 4; i++) bus_wr(8'(8'h42 + i), v[i]);
            read_all();
            tick_chk();
        end
        $display("test random done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
